// *** core/rgc_pkg.sv ***
// package: constants for the reciprocal gate counter
package rgc_pkg;
  localparam int CNT_W = 32;
  localparam int RES_W = 32;
  // register byte offsets
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STAT_OFF = 12'h004;
  localparam logic [11:0] NCYC_OFF = 12'h008;
  localparam logic [11:0] GATE_OFF = 12'h00C;
  localparam logic [11:0] EVT_OFF = 12'h010;
  localparam logic [11:0] TIM_OFF = 12'h014;
  localparam logic [11:0] RES_OFF = 12'h018;
  // control fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_FREQ_BIT = 3;
  localparam int CTRL_ARM_BIT = 4;
  localparam int CTRL_AUTO_BIT = 5;
  // mode codes
  localparam logic [1:0] MODE_PERIOD = 2'h0;
  localparam logic [1:0] MODE_TI = 2'h1;
  localparam logic [1:0] MODE_FREQ = 2'h2;
  // reset values
  localparam logic [CNT_W-1:0] NCYC_RST = 32'h00000001;
  localparam logic [CNT_W-1:0] GATE_RST = 32'h05F5E100;
  // reciprocal numerator: clock rate in hz
  localparam logic [63:0] CLK_HZ = 64'h0000000005F5E100;
  localparam int DIV_CYCLES = 64;
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_ARM = 5'b00010,
    S_OPEN = 5'b00100,
    S_DIV = 5'b01000,
    S_DONE = 5'b10000
  } state_t;
endpackage

// *** core/rgc_divider.sv ***
// sequential restoring divider, one quotient bit per cycle
`timescale 1ns/1ps
module rgc_divider #(
  parameter int W = 64
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // operands
  input wire logic start,
  input wire logic [W-1:0] dividend,
  input wire logic [W-1:0] divisor,
  // result
  output logic busy,
  output logic [W-1:0] quotient
);
  logic [W-1:0] rem_r, rem_nxt, quo_r, quo_nxt, dsr_r, dsr_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [W:0] trial;

  always_comb begin
    rem_nxt = rem_r;
    quo_nxt = quo_r;
    dsr_nxt = dsr_r;
    cnt_nxt = cnt_r;
    trial = {rem_r, quo_r[W-1]};
    if (start) begin
      rem_nxt = '0;
      quo_nxt = dividend;
      dsr_nxt = divisor;
      cnt_nxt = 8'(W);
    end else if (cnt_r != 8'h00) begin
      cnt_nxt = cnt_r - 8'h01;
      if (trial >= {1'b0, dsr_r}) begin
        rem_nxt = W'(trial - {1'b0, dsr_r});
        quo_nxt = {quo_r[W-2:0], 1'b1};
      end else begin
        rem_nxt = trial[W-1:0];
        quo_nxt = {quo_r[W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem_r <= '0;
      quo_r <= '0;
      dsr_r <= '0;
      cnt_r <= 8'h00;
    end else if (ce) begin
      rem_r <= rem_nxt;
      quo_r <= quo_nxt;
      dsr_r <= dsr_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign busy = (cnt_r != 8'h00);
  assign quotient = quo_r;
endmodule

// *** core/rgc_top.sv ***
// reciprocal gate counter: gate control, event/time counters, apb registers
// What this block does
// - every measurement counts clock pulses between input edges, except in frequency mode
// - frequency result is the reciprocal of the measured period
// - time counter counts time-base clock pulses while gate open
// - period mode gate opens and closes on input edges
// - averaging holds gate open over several input cycles, average derived
// - frequency mode opens gate from time-base signal, not input
// - frequency mode closes gate after exact interval, outputs average frequency
// - input faster than clock switches automatically to frequency mode
// - reciprocal range reaches up to the counted clock, not beyond
// - in period and frequency modes, separate event and time counters run together while gate open
// - average period is clock period times time count over event count
// - external arming starts on first input cycle after arm
// - time interval: start opens gate, stop closes it, clocks accumulate
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module rgc_top #(
  parameter int CNT_W = rgc_pkg::CNT_W
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // asynchronous channels
  input wire logic sig_in,
  input wire logic chan_start,
  input wire logic chan_stop,
  input wire logic ext_arm,
  input wire logic fast_in,
  // status
  output logic gate_open,
  output logic meas_done
);
  //////////////////////////////////////////////////////////////////////////
  // synchronisers
  logic [4:0] s1_r, s2_r, s3_r;
  logic in_rise, a_rise, b_rise, arm_rise, fast_lvl;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 5'h00;
      s2_r <= 5'h00;
      s3_r <= 5'h00;
    end else if (ce) begin
      s1_r <= {fast_in, ext_arm, chan_stop, chan_start, sig_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign in_rise = s2_r[0] & ~s3_r[0];
  assign a_rise = s2_r[1] & ~s3_r[1];
  assign b_rise = s2_r[2] & ~s3_r[2];
  assign arm_rise = s2_r[3] & ~s3_r[3];
  assign fast_lvl = s2_r[4];

  //////////////////////////////////////////////////////////////////////////
  // registers
  logic [5:0] ctrl_r, ctrl_nxt;
  logic [CNT_W-1:0] ncyc_r, ncyc_nxt, gate_r, gate_nxt;
  logic apb_wr, apb_rd, start_req, res_read;

  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & penable & ~pwrite;
  assign start_req = apb_wr && paddr == rgc_pkg::CTRL_OFF && pwdata[rgc_pkg::CTRL_START_BIT];
  assign res_read = apb_rd && paddr == rgc_pkg::RES_OFF;
  assign pready = 1'b1;

  always_comb begin
    ctrl_nxt = ctrl_r;
    ncyc_nxt = ncyc_r;
    gate_nxt = gate_r;
    if (apb_wr) begin
      if (paddr == rgc_pkg::CTRL_OFF) begin
        ctrl_nxt = {pwdata[5:1], 1'b0};
      end else if (paddr == rgc_pkg::NCYC_OFF) begin
        ncyc_nxt = (pwdata[CNT_W-1:0] == '0) ? rgc_pkg::NCYC_RST : pwdata[CNT_W-1:0];
      end else if (paddr == rgc_pkg::GATE_OFF) begin
        gate_nxt = (pwdata[CNT_W-1:0] == '0) ? rgc_pkg::GATE_RST : pwdata[CNT_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 6'h00;
      ncyc_r <= rgc_pkg::NCYC_RST;
      gate_r <= rgc_pkg::GATE_RST;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
      ncyc_r <= ncyc_nxt;
      gate_r <= gate_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // gate state machine and counters
  rgc_pkg::state_t st_r, st_nxt;
  logic [CNT_W-1:0] evt_r, evt_nxt, tim_r, tim_nxt;
  logic [1:0] mode_r, mode_nxt;
  localparam int RES_W_L = rgc_pkg::RES_W;
  logic [RES_W_L-1:0] res_r, res_nxt;
  logic done_r, done_nxt, div_go, div_busy, div_go_r, div_go_nxt;
  logic [63:0] div_a, div_b, div_q;
  logic [1:0] sel_mode;
  logic open_ev, close_ev;

  // mode comes from the start write itself; fast input forces counting when auto set
  assign sel_mode = (pwdata[rgc_pkg::CTRL_AUTO_BIT] && fast_lvl) ? rgc_pkg::MODE_FREQ :
                    pwdata[rgc_pkg::CTRL_MODE_LSB +: 2];

  always_comb begin
    open_ev = 1'b0;
    close_ev = 1'b0;
    case (mode_r)
      rgc_pkg::MODE_TI: begin
        open_ev = a_rise;
        close_ev = b_rise;
      end
      rgc_pkg::MODE_FREQ: begin
        open_ev = 1'b1;
        close_ev = (tim_r + 1'b1 >= gate_r);
      end
      default: begin
        open_ev = in_rise;
        close_ev = in_rise && (evt_r + 1'b1 >= ncyc_r);
      end
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    evt_nxt = evt_r;
    tim_nxt = tim_r;
    mode_nxt = mode_r;
    done_nxt = done_r;
    div_go_nxt = 1'b0;
    if (res_read) begin
      done_nxt = 1'b0;
    end
    if (start_req) begin
      st_nxt = pwdata[rgc_pkg::CTRL_ARM_BIT] ? rgc_pkg::S_ARM : rgc_pkg::S_IDLE;
      mode_nxt = sel_mode;
      evt_nxt = '0;
      tim_nxt = '0;
      done_nxt = 1'b0;
    end else begin
      case (st_r)
        rgc_pkg::S_ARM: begin
          if (arm_rise) begin
            st_nxt = rgc_pkg::S_IDLE;
          end
        end
        rgc_pkg::S_IDLE: begin
          if (open_ev && !done_r && mode_r != 2'h3 && evt_r == '0 && tim_r == '0 &&
              !div_busy) begin
            st_nxt = rgc_pkg::S_OPEN;
          end
        end
        rgc_pkg::S_OPEN: begin
          tim_nxt = tim_r + 1'b1;
          if (mode_r == rgc_pkg::MODE_FREQ ? in_rise : (in_rise && mode_r != rgc_pkg::MODE_TI))
            evt_nxt = evt_r + 1'b1;
          if (close_ev) begin
            st_nxt = rgc_pkg::S_DIV;
            div_go_nxt = 1'b1;
          end
        end
        rgc_pkg::S_DIV: begin
          if (!div_go_r && !div_busy) begin
            st_nxt = rgc_pkg::S_DONE;
            done_nxt = 1'b1;
          end
        end
        default: begin
          st_nxt = rgc_pkg::S_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= rgc_pkg::S_DONE;
      evt_r <= '0;
      tim_r <= '0;
      mode_r <= rgc_pkg::MODE_PERIOD;
      done_r <= 1'b0;
      div_go_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      evt_r <= evt_nxt;
      tim_r <= tim_nxt;
      mode_r <= mode_nxt;
      done_r <= done_nxt;
      div_go_r <= div_go_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // arithmetic: period = time/events (in clocks), frequency = clk_hz*events/time
  logic want_freq;
  assign want_freq = ctrl_r[rgc_pkg::CTRL_FREQ_BIT] || mode_r == rgc_pkg::MODE_FREQ;

  always_comb begin
    div_a = {{(64 - CNT_W){1'b0}}, tim_r};
    div_b = {{(64 - CNT_W){1'b0}}, (evt_r == '0) ? {{(CNT_W - 1){1'b0}}, 1'b1} : evt_r};
    if (want_freq) begin
      div_a = 64'(rgc_pkg::CLK_HZ * {{(64 - CNT_W){1'b0}}, evt_r});
      div_b = {{(64 - CNT_W){1'b0}}, (tim_r == '0) ? {{(CNT_W - 1){1'b0}}, 1'b1} : tim_r};
    end
    if (mode_r == rgc_pkg::MODE_TI) begin
      div_b = 64'h0000000000000001;
    end
  end

  rgc_divider #(.W(64)) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .start(div_go_r),
    .dividend(div_a),
    .divisor(div_b),
    .busy(div_busy),
    .quotient(div_q)
  );

  always_comb begin
    res_nxt = res_r;
    if (st_r == rgc_pkg::S_DIV && !div_go_r && !div_busy)
      res_nxt = div_q[RES_W_L-1:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) res_r <= '0;
    else if (ce) res_r <= res_nxt;
  end

  //////////////////////////////////////////////////////////////////////////
  // apb read mux
  always_comb begin
    prdata = 32'h00000000;
    pslverr = 1'b0;
    if (apb_rd) begin
      if (paddr == rgc_pkg::CTRL_OFF) prdata = {26'h0, ctrl_r};
      else if (paddr == rgc_pkg::STAT_OFF)
        prdata = {24'h000000, 3'h0, st_r == rgc_pkg::S_ARM, mode_r, gate_open, done_r};
      else if (paddr == rgc_pkg::NCYC_OFF) prdata = 32'(ncyc_r);
      else if (paddr == rgc_pkg::GATE_OFF) prdata = 32'(gate_r);
      else if (paddr == rgc_pkg::EVT_OFF) prdata = 32'(evt_r);
      else if (paddr == rgc_pkg::TIM_OFF) prdata = 32'(tim_r);
      else if (paddr == rgc_pkg::RES_OFF) prdata = res_r;
      else pslverr = 1'b1;
    end else if (psel && penable && !(paddr inside {rgc_pkg::CTRL_OFF, rgc_pkg::NCYC_OFF,
                 rgc_pkg::GATE_OFF})) begin
      pslverr = 1'b1;
    end
  end

  assign gate_open = (st_r == rgc_pkg::S_OPEN);
  assign meas_done = done_r;

  //////////////////////////////////////////////////////////////////////////
  // assertions
  property p_tim_frozen;
    @(posedge pclk) disable iff (!presetn)
      (ce && st_r != rgc_pkg::S_OPEN && !start_req) |=> $stable(tim_r);
  endproperty
  a_tim_frozen: assert property (p_tim_frozen) else $error("time count moved, gate shut");

  property p_tim_counts;
    @(posedge pclk) disable iff (!presetn)
      (ce && st_r == rgc_pkg::S_OPEN && !start_req) |=> tim_r == $past(tim_r) + 1'b1;
  endproperty
  a_tim_counts: assert property (p_tim_counts) else $error("time count did not step");

  property p_ti_close;
    @(posedge pclk) disable iff (!presetn)
      (ce && st_r == rgc_pkg::S_OPEN && mode_r == rgc_pkg::MODE_TI && b_rise && !start_req)
      |=> st_r == rgc_pkg::S_DIV;
  endproperty
  a_ti_close: assert property (p_ti_close) else $error("stop did not close gate");

  property p_arm_wait;
    @(posedge pclk) disable iff (!presetn)
      (st_r == rgc_pkg::S_ARM && !arm_rise && !start_req) |=> st_r == rgc_pkg::S_ARM;
  endproperty
  a_arm_wait: assert property (p_arm_wait) else $error("left arm wait early");

  property p_done_hold;
    @(posedge pclk) disable iff (!presetn)
      (ce && done_r && !res_read && !start_req) |=> done_r;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done dropped early");

  property p_evt_ti;
    @(posedge pclk) disable iff (!presetn)
      (mode_r == rgc_pkg::MODE_TI && !start_req) |=> evt_r == '0;
  endproperty
  a_evt_ti: assert property (p_evt_ti) else $error("events counted in interval mode");

  property p_fast_mode;
    @(posedge pclk) disable iff (!presetn)
      (ce && start_req && pwdata[rgc_pkg::CTRL_AUTO_BIT] && fast_lvl)
      |=> mode_r == rgc_pkg::MODE_FREQ;
  endproperty
  a_fast_mode: assert property (p_fast_mode) else $error("no fallback to frequency mode");

  property p_done_after;
    @(posedge pclk) disable iff (!presetn)
      (ce && gate_open && close_ev && !start_req) |=> ##[1:80] (done_r || start_req || !ce);
  endproperty
  a_done_after: assert property (p_done_after) else $error("no result after gate close");
endmodule

// *** dv/rgc_partner.sv ***
// partner model: conditioned input channels and arming source
`timescale 1ns/1ps
module rgc_partner (
  // bench control
  input wire logic run,
  input wire logic [31:0] half_ns,
  input wire logic [31:0] ti_ns,
  input wire logic ti_go,
  input wire logic arm_go,
  input wire logic fast,
  // channels
  output logic sig_in,
  output logic chan_start,
  output logic chan_stop,
  output logic ext_arm,
  output logic fast_in
);
  initial begin
    sig_in = 1'b0;
    chan_start = 1'b0;
    chan_stop = 1'b0;
    ext_arm = 1'b0;
    fast_in = 1'b0;
    #3;
    // free-running input, edges kept off the clock edges
    forever begin
      #(half_ns);
      sig_in = run ? ~sig_in : 1'b0;
    end
  end
  // start pulse on channel a, stop pulse on channel b
  always @(ti_go) begin
    #3 chan_start = 1'b1;
    #20 chan_start = 1'b0;
    #(ti_ns - 20) chan_stop = 1'b1;
    #20 chan_stop = 1'b0;
  end
  always @(arm_go) begin
    #3 ext_arm = arm_go;
  end
  always @(fast) begin
    #3 fast_in = fast;
  end
endmodule

// *** dv/reciprocal_gate_counter_tb.sv ***
// self-checking bench for the reciprocal gate counter
`timescale 1ns/1ps
module reciprocal_gate_counter_tb;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, gate_open, meas_done;
  logic sig_in, chan_start, chan_stop, ext_arm, fast_in;
  logic run = 1'b0, ti_go = 1'b0, arm_go = 1'b0, fast = 1'b0;
  int half_ns = 100, ti_ns = 300, seed = 81, pcyc, nc, n;
  int failures = 0, cmp_count = 0, cyc = 0;
  logic [33:0] notes[$];
  logic [33:0] note;
  logic seen_open;
  always #5 pclk = ~pclk;
  rgc_top uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sig_in(sig_in), .chan_start(chan_start), .chan_stop(chan_stop),
    .ext_arm(ext_arm), .fast_in(fast_in), .gate_open(gate_open), .meas_done(meas_done));
  rgc_partner peer (.run(run), .half_ns(half_ns), .ti_ns(ti_ns), .ti_go(ti_go),
    .arm_go(arm_go), .fast(fast), .sig_in(sig_in), .chan_start(chan_start),
    .chan_stop(chan_stop), .ext_arm(ext_arm), .fast_in(fast_in));
  ////////////////////////////////////////////////////////////////////////////////
  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // apb transfer, expectation noted first
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
    notes.push_back({~w, err, d});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // start, optional kick (1 interval, 2 arm), then read back counts
  task meas(input string nm, input logic [31:0] ctrl, input int k, input logic [31:0] ev,
    input logic [31:0] tm, input logic [31:0] res);
    apb(1'b1, rgc_pkg::CTRL_OFF, ctrl, 1'b0);
    if (k == 1) ti_go <= ~ti_go;
    if (k == 2) begin
      repeat (30) @(posedge pclk);
      check("gate_open", {31'h0, gate_open}, 32'h0);
      apb(1'b0, rgc_pkg::STAT_OFF, 32'h00000010, 1'b0);
      arm_go <= ~arm_go;
    end
    n = 0;
    seen_open = 1'b0;
    while (meas_done !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      if (gate_open === 1'b1) seen_open = 1'b1;
      n++;
    end
    check("gate_seen", {31'h0, seen_open}, 32'h1);
    check("meas_done", {31'h0, meas_done}, 32'h1);
    apb(1'b0, rgc_pkg::EVT_OFF, ev, 1'b0);
    apb(1'b0, rgc_pkg::TIM_OFF, tm, 1'b0);
    apb(1'b0, rgc_pkg::RES_OFF, res, 1'b0);
    #1 check("meas_done", {31'h0, meas_done}, 32'h0);
    apb(1'b0, rgc_pkg::TIM_OFF, tm, 1'b0);
    $display("test %s done", nm);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      note = notes.pop_front();
      check("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
      if (note[33]) check("prdata", prdata, note[31:0]);
    end
    cyc++;
    if (cyc == 40000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    check("gate_open", {31'h0, gate_open}, 32'h0);
    check("meas_done", {31'h0, meas_done}, 32'h0);
    apb(1'b0, rgc_pkg::STAT_OFF, 32'h00000000, 1'b0);
    apb(1'b0, rgc_pkg::NCYC_OFF, rgc_pkg::NCYC_RST, 1'b0);
    apb(1'b0, rgc_pkg::GATE_OFF, rgc_pkg::GATE_RST, 1'b0);
    apb(1'b0, 12'h01C, 32'h00000000, 1'b1);
    apb(1'b1, rgc_pkg::STAT_OFF, 32'h00000001, 1'b1);
    apb(1'b1, rgc_pkg::NCYC_OFF, 32'h00000000, 1'b0);
    apb(1'b0, rgc_pkg::NCYC_OFF, 32'h00000001, 1'b0);
    $display("test registers done");
    run <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      pcyc = 10 + ($random(seed) & 15);
      nc = 1 + ($random(seed) & 3);
      half_ns = 5 * pcyc;
      apb(1'b1, rgc_pkg::NCYC_OFF, nc, 1'b0);
      meas("period", 32'h00000001, 0, nc, nc * pcyc, pcyc);
      meas("recip", 32'h00000009, 0, nc, nc * pcyc, 100000000 / pcyc);
    end
    half_ns = 100;
    apb(1'b1, rgc_pkg::NCYC_OFF, 32'h00000001, 1'b0);
    meas("armed", 32'h00000011, 2, 32'h1, 32'h14, 32'h14);
    apb(1'b1, rgc_pkg::GATE_OFF, 32'h00000064, 1'b0);
    meas("freq", 32'h00000005, 0, 32'h5, 32'h64, 32'h004C4B40);
    fast <= 1'b1;
    meas("fallback", 32'h00000021, 0, 32'h5, 32'h64, 32'h004C4B40);
    fast <= 1'b0;
    run <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      ti_ns = 10 * (20 + ($random(seed) & 31));
      meas("interval", 32'h00000003, 1, 32'h0, ti_ns / 10, ti_ns / 10);
    end
    tally_and_finish();
  end
endmodule
